/* File: common/cmif_pkg.sv */
// shared constants, frame carrier and identifier byte packing
package cmif_pkg;
    // register byte addresses, one aligned word each
    localparam logic [7:0] OFS_TX_ID0   = 8'h00;
    localparam logic [7:0] OFS_RX_ID0   = 8'h10;
    localparam logic [7:0] OFS_TX_EMPTY = 8'h20;
    localparam logic [7:0] OFS_TX_SEL   = 8'h24;
    localparam logic [7:0] OFS_RX_FULL  = 8'h28;
    localparam logic [7:0] OFS_STATUS   = 8'h2c;
    // field positions inside the identifier bytes
    localparam int EXT_SRR_BIT = 4;
    localparam int EXT_IDE_BIT = 3;
    localparam int EXT_RTR_BIT = 0;
    localparam int STD_RTR_BIT = 4;
    localparam int STD_IDE_BIT = 3;
    // arbitration field lengths in bits
    localparam logic [5:0] EXT_LEN = 6'h20;
    localparam logic [5:0] STD_LEN = 6'h0d;
    // sequence positions of control bits in the arbitration field
    localparam logic [5:0] POS_SRR_OR_STD_RTR = 6'h0b;
    localparam logic [5:0] POS_IDE            = 6'h0c;
    // reset values
    localparam logic TX_EMPTY_RST = 1'b1;
    localparam logic RX_FULL_RST  = 1'b0;
    localparam logic TX_SEL_RST   = 1'b0;
    // core clock cycles per arbitration bit
    localparam int BIT_DIV_DEF = 8;

    typedef struct packed {
        logic        ext;
        logic [28:0] id;
        logic        srr;
        logic        rtr;
    } cmif_id_s;

    // fields to bytes 0..3, byte 0 in bits 31:24
    function automatic logic [31:0] cmif_pack(input cmif_id_s f);
        if (f.ext)
            cmif_pack = {f.id[28:18], f.srr, 1'b1, f.id[17:0], f.rtr};
        else
            cmif_pack = {f.id[10:0], f.rtr, 1'b0, 19'h0};
    endfunction

    // bytes to arbitration key, sent msb first, lowest value wins
    function automatic logic [31:0] cmif_key(input logic [31:0] w);
        if (w[16 + EXT_IDE_BIT])
            cmif_key = {w[31:21], 1'b1, 1'b1, w[18:0]};
        else
            cmif_key = {w[31:21], w[16 + STD_RTR_BIT], 1'b0, 19'h0};
    endfunction
endpackage

/* File: verilog/cmif_tx_arb.sv */
// picks the pending transmit buffer with the lowest arbitration key
`timescale 1ns/10ps
module cmif_tx_arb
    import cmif_pkg::*;
#(
    parameter int N_TX = 3
)(
    input  wire logic [N_TX-1:0]     pend,
    input  wire logic [31:0]         keys [N_TX],
    output logic                     sel_valid,
    output logic [((N_TX > 1) ? $clog2(N_TX) : 1)-1:0] sel_idx
);
    localparam int AW = (N_TX > 1) ? $clog2(N_TX) : 1;

    always_comb
    begin
        sel_valid = 1'b0;
        sel_idx   = '0;
        for (int i = 0; i < N_TX; i++)
        begin
            if (pend[i] && (!sel_valid || keys[i] < keys[sel_idx]))
            begin
                sel_valid = 1'b1;
                sel_idx   = i[AW-1:0];
            end
        end
    end
endmodule

/* File: verilog/cmif_tx_serial.sv */
// shifts an arbitration field out msb first at the bit rate
`timescale 1ns/10ps
module cmif_tx_serial
    import cmif_pkg::*;
#(
    parameter int BIT_DIV = BIT_DIV_DEF
)(
    input  wire logic        core_clk,
    input  wire logic        nrst,
    input  wire logic        load,
    input  wire logic [31:0] key,
    output logic             busy,
    output logic             bit_out,
    output logic             bit_valid,
    output logic             done
);
    initial
    begin
        if (BIT_DIV < 2 || BIT_DIV > 256) $error("BIT_DIV must be 2 to 256");
    end

    // cycles from busy to the first bit pulse
    localparam int FIRST_LAT = BIT_DIV;

    localparam int DW = $clog2(BIT_DIV);
    localparam logic [DW-1:0] DIV_LAST = DW'(BIT_DIV - 1);

    logic [DW-1:0] div_r;
    logic          bit_en;
    logic [31:0]   shreg_r;
    logic [5:0]    remain_r;
    logic          ext_r;
    logic [31:0]   key_r;
    logic [5:0]    sent_r;

    assign bit_en = (div_r == DIV_LAST);

    // bit rate divider
    always_ff @(posedge core_clk)
    begin
        if (!nrst || !busy || bit_en)
            div_r <= '0;
        else
            div_r <= div_r + 1'b1;
    end

    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            busy      <= 1'b0;
            bit_out   <= 1'b1;
            bit_valid <= 1'b0;
            done      <= 1'b0;
            remain_r  <= '0;
            shreg_r   <= '0;
            ext_r     <= 1'b0;
            key_r     <= '0;
        end
        else
        begin
            bit_valid <= 1'b0;
            done      <= 1'b0;
            if (load && !busy)
            begin
                busy     <= 1'b1;
                shreg_r  <= key;
                key_r    <= key;
                ext_r    <= key[31 - POS_IDE];
                remain_r <= key[31 - POS_IDE] ? EXT_LEN : STD_LEN;
            end
            else if (busy && bit_en)
            begin
                bit_out   <= shreg_r[31];
                bit_valid <= 1'b1;
                shreg_r   <= {shreg_r[30:0], 1'b0};
                remain_r  <= remain_r - 1'b1;
                if (remain_r == 6'h01)
                begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end
            end
        end
    end

    // sequence position of the bit now on bit_out
    always_ff @(posedge core_clk)
    begin
        if (!nrst || (load && !busy))
            sent_r <= '0;
        else if (bit_valid)
            sent_r <= sent_r + 1'b1;
    end

    sequence s_frame_start;
        load && !busy;
    endsequence

    sequence s_first_bit;
        bit_valid && sent_r == 6'h00;
    endsequence

    chk_first_bit_msb: assert property (
        @(posedge core_clk) disable iff (!nrst)
        s_first_bit |-> bit_out == key_r[31])
        else $error("first bit is not the identifier msb");

    chk_srr_recessive: assert property (
        @(posedge core_clk) disable iff (!nrst)
        bit_valid && ext_r && sent_r == POS_SRR_OR_STD_RTR |-> bit_out)
        else $error("srr not recessive");

    chk_frame_length: assert property (
        @(posedge core_clk) disable iff (!nrst)
        done |-> sent_r == (ext_r ? EXT_LEN - 6'h01 : STD_LEN - 6'h01))
        else $error("arbitration field length wrong");

    chk_ide_sent: assert property (
        @(posedge core_clk) disable iff (!nrst)
        bit_valid && sent_r == POS_IDE |-> bit_out == ext_r)
        else $error("ide bit does not match format");

    chk_load_first: assert property (
        @(posedge core_clk) disable iff (!nrst)
        s_frame_start |=> busy ##[1:FIRST_LAT] s_first_bit)
        else $error("no first bit after load");
endmodule

/* File: verilog/cmif_top.sv */
// identifier buffers with avalon slave, receive store and transmit arbiter
//
// Contract
// - extended identifier record is 32 bits
// - standard identifier record is 13 bits
// - byte 0 holds extended id 28..21
// - byte 1: id 20..18, srr, ide, 17..15
// - byte 2 holds id 14..7, no reset
// - byte 3 holds id 6..0 and rtr
// - id 28 is msb, sent first
// - lowest identifier value wins arbitration
// - srr is fixed recessive, extended only
// - received srr stored as sampled
// - ide zero standard, one extended
// - received ide stored as received
// - transmit ide selects sent format
// - received rtr: zero data, one remote
// - transmit rtr sent as written
// - standard mapping: id 10..0, rtr, ide
// - access gated by empty/select and full flags
`timescale 1ns/10ps
module cmif_top
    import cmif_pkg::*;
#(
    parameter int N_TX    = 3,
    parameter int BIT_DIV = BIT_DIV_DEF
)(
    input  wire logic        core_clk,
    input  wire logic        nrst,
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        rx_valid,
    input  wire cmif_id_s    rx_frame,
    output logic             tx_bit,
    output logic             tx_bit_valid,
    output logic             tx_busy,
    output logic             tx_done
);
    initial
    begin
        if (N_TX < 1 || N_TX > 8) $error("N_TX must be 1 to 8");
    end

    localparam int IW = (N_TX > 1) ? $clog2(N_TX) : 1;

    logic [31:0]   tx_id_mem [N_TX];
    logic [31:0]   rx_id_r;
    logic [N_TX-1:0] tx_empty_r;
    logic [N_TX-1:0] tx_sel_r;
    logic          rx_full_r;
    logic          rx_overrun_r;
    logic          load_r;
    logic [IW-1:0] cur_idx_r;
    logic [31:0]   keys [N_TX];
    logic [N_TX-1:0] pend;
    logic          arb_valid;
    logic [IW-1:0] arb_idx;
    logic          ser_busy;
    logic          ser_bit;
    logic          ser_valid;
    logic          ser_done;
    logic          req;
    logic          acc;
    logic          acc_wr;
    logic [1:0]    byte_sel;
    logic          hit_tx;
    logic          hit_rx;
    logic          sw_sel_valid;
    logic [IW-1:0] sw_idx;
    logic          tx_open;

    // first selected buffer in the select mask
    function automatic logic [IW:0] first_set(input logic [N_TX-1:0] m);
        first_set = '0;
        for (int i = N_TX - 1; i >= 0; i--)
        begin
            if (m[i])
                first_set = {1'b1, i[IW-1:0]};
        end
    endfunction

    // byte lane of a buffer word, byte 0 on top
    function automatic logic [7:0] pick_byte(input logic [31:0] w,
                                             input logic [1:0]  b);
        pick_byte = w[8 * (3 - b) +: 8];
    endfunction

    assign req      = avs_read || avs_write;
    assign acc      = req && !avs_waitrequest;
    assign acc_wr   = acc && avs_write && avs_byteenable[0];
    assign byte_sel = avs_address[3:2];
    assign hit_tx   = (avs_address[7:4] == OFS_TX_ID0[7:4]);
    assign hit_rx   = (avs_address[7:4] == OFS_RX_ID0[7:4]);
    assign {sw_sel_valid, sw_idx} = first_set(tx_sel_r);
    // transmit bytes open when empty and selected
    assign tx_open  = sw_sel_valid && tx_empty_r[sw_idx];

    // one wait state, then the answer stands for one cycle
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
            avs_waitrequest <= 1'b1;
        else
            avs_waitrequest <= !(req && avs_waitrequest);
    end

    // read data mux, closed or unmapped reads give zero
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
            avs_readdata <= '0;
        else if (avs_read && avs_waitrequest)
        begin
            avs_readdata <= '0;
            if (hit_tx && tx_open)
                avs_readdata[7:0] <= pick_byte(tx_id_mem[sw_idx], byte_sel);
            else if (hit_rx && rx_full_r)
                avs_readdata[7:0] <= pick_byte(rx_id_r, byte_sel);
            else if (avs_address == OFS_TX_EMPTY)
                avs_readdata[N_TX-1:0] <= tx_empty_r;
            else if (avs_address == OFS_TX_SEL)
                avs_readdata[N_TX-1:0] <= tx_sel_r;
            else if (avs_address == OFS_RX_FULL)
                avs_readdata[0] <= rx_full_r;
            else if (avs_address == OFS_STATUS)
                avs_readdata[2:0] <= {rx_overrun_r, load_r, ser_busy};
        end
    end

    // bytes held as written, no reset
    always_ff @(posedge core_clk)
    begin
        if (acc_wr && hit_tx && tx_open)
            tx_id_mem[sw_idx][8 * (3 - byte_sel) +: 8] <= avs_writedata[7:0];
    end

    // store received fields in buffer layout
    always_ff @(posedge core_clk)
    begin
        if (rx_valid && !rx_full_r)
            rx_id_r <= cmif_pack(rx_frame);
    end

    // receive full flag, arrival wins over a clear
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            rx_full_r    <= RX_FULL_RST;
            rx_overrun_r <= 1'b0;
        end
        else
        begin
            if (rx_valid)
                rx_full_r <= 1'b1;
            else if (acc_wr && avs_address == OFS_RX_FULL
                     && avs_writedata[0])
                rx_full_r <= 1'b0;
            if (rx_valid && rx_full_r)
                rx_overrun_r <= 1'b1;
            else if (acc_wr && avs_address == OFS_STATUS
                     && avs_writedata[2])
                rx_overrun_r <= 1'b0;
        end
    end

    // buffer select register
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
            tx_sel_r <= {N_TX{TX_SEL_RST}};
        else if (acc_wr && avs_address == OFS_TX_SEL)
            tx_sel_r <= avs_writedata[N_TX-1:0];
    end

    // empty flags: writing one queues a buffer, completion sets it again
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
            tx_empty_r <= {N_TX{TX_EMPTY_RST}};
        else
        begin
            for (int i = 0; i < N_TX; i++)
            begin
                if (ser_done && cur_idx_r == i[IW-1:0])
                    tx_empty_r[i] <= 1'b1;
                else if (acc_wr && avs_address == OFS_TX_EMPTY
                         && avs_writedata[i])
                    tx_empty_r[i] <= 1'b0;
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < N_TX; g++)
        begin : g_keys
            // key layout follows the format flag
            assign keys[g] = cmif_key(tx_id_mem[g]);
            assign pend[g] = !tx_empty_r[g];
        end
    endgenerate

    cmif_tx_arb #(
        .N_TX      (N_TX)
    ) u_arb (
        .pend      (pend),
        .keys      (keys),
        .sel_valid (arb_valid),
        .sel_idx   (arb_idx)
    );

    // start the winning buffer when the serializer is idle
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            load_r    <= 1'b0;
            cur_idx_r <= '0;
        end
        else
        begin
            // a finishing buffer still looks pending for one cycle
            load_r <= arb_valid && !ser_busy && !ser_done && !load_r;
            if (arb_valid && !ser_busy && !ser_done && !load_r)
                cur_idx_r <= arb_idx;
        end
    end

    cmif_tx_serial #(
        .BIT_DIV   (BIT_DIV)
    ) u_ser (
        .core_clk  (core_clk),
        .nrst      (nrst),
        .load      (load_r),
        .key       (keys[cur_idx_r]),
        .busy      (ser_busy),
        .bit_out   (ser_bit),
        .bit_valid (ser_valid),
        .done      (ser_done)
    );

    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            tx_bit       <= 1'b1;
            tx_bit_valid <= 1'b0;
            tx_busy      <= 1'b0;
            tx_done      <= 1'b0;
        end
        else
        begin
            tx_bit       <= ser_bit;
            tx_bit_valid <= ser_valid;
            tx_busy      <= ser_busy || load_r;
            tx_done      <= ser_done;
        end
    end

    chk_rx_ext_layout: assert property (
        @(posedge core_clk) disable iff (!nrst)
        rx_valid && !rx_full_r && rx_frame.ext |=>
            rx_id_r[16 + EXT_IDE_BIT] &&
            rx_id_r[16 + EXT_SRR_BIT] == $past(rx_frame.srr) &&
            rx_id_r[31:24] == $past(rx_frame.id[28:21]) &&
            rx_id_r[7:1] == $past(rx_frame.id[6:0]) &&
            rx_id_r[EXT_RTR_BIT] == $past(rx_frame.rtr))
        else $error("extended receive layout wrong");

    chk_rx_std_layout: assert property (
        @(posedge core_clk) disable iff (!nrst)
        rx_valid && !rx_full_r && !rx_frame.ext |=>
            !rx_id_r[16 + STD_IDE_BIT] &&
            rx_id_r[31:21] == $past(rx_frame.id[10:0]) &&
            rx_id_r[16 + STD_RTR_BIT] == $past(rx_frame.rtr))
        else $error("standard receive layout wrong");

    chk_tx_closed_write: assert property (
        @(posedge core_clk) disable iff (!nrst)
        acc_wr && hit_tx && !tx_open |=> $stable(tx_id_mem[sw_idx]))
        else $error("closed transmit buffer was written");

    chk_rx_read_gate: assert property (
        @(posedge core_clk) disable iff (!nrst)
        avs_read && avs_waitrequest && hit_rx && !rx_full_r
            |=> avs_readdata == 32'h0 && !avs_waitrequest)
        else $error("receive bytes readable while not full");

    chk_rx_full_set: assert property (
        @(posedge core_clk) disable iff (!nrst)
        rx_valid |=> rx_full_r)
        else $error("receive full not set by arrival");

    chk_done_frees: assert property (
        @(posedge core_clk) disable iff (!nrst)
        ser_done |=> tx_empty_r[$past(cur_idx_r)] && tx_done)
        else $error("sent buffer not freed");
endmodule

/* File: verif/cmif_engine_model.sv */
// protocol engine stand-in: delivers received fields, collects sent bits
`timescale 1ns/10ps
module cmif_engine_model
    import cmif_pkg::*;
(
    input  wire logic     core_clk,
    input  wire logic     nrst,
    input  wire logic     send,
    input  wire cmif_id_s frame_in,
    output logic          rx_valid,
    output cmif_id_s      rx_frame,
    input  wire logic     tx_bit,
    input  wire logic     tx_bit_valid,
    input  wire logic     tx_done,
    output logic [31:0]   got_word,
    output logic [7:0]    got_cnt
);
    logic [31:0] sh_r;

    // one-cycle delivery; fields toggle while not valid
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            rx_valid <= 1'b0;
            rx_frame <= '0;
        end
        else
        begin
            rx_valid <= send;
            rx_frame <= send ? frame_in : ~rx_frame;
        end
    end

    // sent bits shifted in, last bit at bit 0, frame latched on done
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            sh_r     <= '0;
            got_word <= '0;
            got_cnt  <= '0;
        end
        else if (tx_done)
        begin
            got_word <= tx_bit_valid ? {sh_r[30:0], tx_bit} : sh_r;
            got_cnt  <= got_cnt + 8'h01;
            sh_r     <= '0;
        end
        else if (tx_bit_valid)
            sh_r <= {sh_r[30:0], tx_bit};
    end
endmodule

/* File: verif/can_msg_identifier_fields_bench.sv */
// self-checking bench for the identifier buffers
`timescale 1ns/10ps
module can_msg_identifier_fields_bench;
    import cmif_pkg::*;

    logic        core_clk;
    logic        nrst;
    logic [7:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        rx_valid;
    cmif_id_s    rx_frame;
    logic        tx_bit;
    logic        tx_bit_valid;
    logic        tx_busy;
    logic        tx_done;
    logic        send;
    cmif_id_s    frame_in;
    logic [31:0] got_word;
    logic [7:0]  got_cnt;
    int          err_count;
    int          comparisons;
    cmif_id_s    fr [3];
    cmif_id_s    rf;
    logic [31:0] q;

    cmif_top #(.N_TX(3), .BIT_DIV(2)) dut (
        .core_clk        (core_clk),
        .nrst            (nrst),
        .avs_address     (avs_address),
        .avs_read        (avs_read),
        .avs_write       (avs_write),
        .avs_writedata   (avs_writedata),
        .avs_byteenable  (4'hf),
        .avs_readdata    (avs_readdata),
        .avs_waitrequest (avs_waitrequest),
        .rx_valid        (rx_valid),
        .rx_frame        (rx_frame),
        .tx_bit          (tx_bit),
        .tx_bit_valid    (tx_bit_valid),
        .tx_busy         (tx_busy),
        .tx_done         (tx_done)
    );

    cmif_engine_model eng (
        .core_clk     (core_clk),
        .nrst         (nrst),
        .send         (send),
        .frame_in     (frame_in),
        .rx_valid     (rx_valid),
        .rx_frame     (rx_frame),
        .tx_bit       (tx_bit),
        .tx_bit_valid (tx_bit_valid),
        .tx_done      (tx_done),
        .got_word     (got_word),
        .got_cnt      (got_cnt)
    );

    always #12.5 core_clk = ~core_clk;

    // expected register bytes, byte 0 on top
    function automatic logic [31:0] id_bytes(input cmif_id_s f);
        if (f.ext)
            return {f.id[28:18], f.srr, 1'b1, f.id[17:0], f.rtr};
        return {f.id[10:0], f.rtr, 1'b0, 19'h0};
    endfunction

    // expected arbitration field, last bit sent at bit 0
    function automatic logic [31:0] arb_seq(input cmif_id_s f);
        if (f.ext)
            return {f.id[28:18], 1'b1, 1'b1, f.id[17:0], f.rtr};
        return {19'h0, f.id[10:0], f.rtr, 1'b0};
    endfunction

    task automatic check32(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic bus_xfer(input logic rd, input logic [7:0] a,
                            input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        avs_address   <= a;
        avs_writedata <= d;
        avs_read      <= rd;
        avs_write     <= !rd;
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 20);
        if (avs_waitrequest !== 1'b0)
            err_count++;
        r = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        bus_xfer(1'b1, a, 32'h0, r);
        check32({24'h0, r[7:0]}, exp);
    endtask

    // write (when wr) and read back the four id bytes at base
    task automatic id_words(input logic [7:0] base, input logic wr,
                            input cmif_id_s f);
        logic [31:0] w;
        logic [31:0] r;
        w = id_bytes(f);
        for (int b = 0; b < 4; b++)
        begin
            if (wr)
                bus_xfer(1'b0, base + 8'(4 * b), {24'h0, w[31-8*b -: 8]}, r);
            rd_chk(base + 8'(4 * b), {24'h0, w[31-8*b -: 8]});
        end
    endtask

    task automatic wait_frame(input logic [7:0] k, input logic [31:0] exp);
        int n;
        n = 0;
        while (got_cnt !== k && n < 2000)
        begin
            @(posedge core_clk);
            n++;
        end
        if (got_cnt !== k)
            err_count++;
        check32(got_word, exp);
    endtask

    task automatic rx_send(input cmif_id_s f);
        frame_in <= f;
        send     <= 1'b1;
        @(posedge core_clk);
        send <= 1'b0;
        repeat (4) @(posedge core_clk);
    endtask

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge core_clk);
        err_count++;
        wrap_up();
    end

    initial
    begin
        core_clk = 1'b0;
        nrst = 1'b0;
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        send = 1'b0;
        frame_in = '0;
        err_count = 0;
        comparisons = 0;
        repeat (8) @(posedge core_clk);
        nrst <= 1'b1;
        @(posedge core_clk);
        // flags after reset, unmapped and closed places
        rd_chk(OFS_TX_EMPTY, 32'h7);
        rd_chk(OFS_TX_SEL, 32'h0);
        rd_chk(OFS_RX_FULL, 32'h0);
        rd_chk(8'h3c, 32'h0);
        rd_chk(OFS_RX_ID0, 32'h0);
        bus_xfer(1'b0, OFS_TX_ID0, 32'h5a, q);
        rd_chk(OFS_TX_ID0, 32'h0);
        $display("test reset_and_gating done");
        // three buffers, lowest key last written; srr written as one
        fr[0] = '{ext: 1'b1, id: 29'h1abcdef1, srr: 1'b1, rtr: 1'b0};
        fr[1] = '{ext: 1'b0, id: 29'h0000100, srr: 1'b0, rtr: 1'b1};
        fr[2] = '{ext: 1'b1, id: 29'h0123456, srr: 1'b1, rtr: 1'b0};
        for (int i = 0; i < 3; i++)
        begin
            bus_xfer(1'b0, OFS_TX_SEL, 32'h1 << i, q);
            id_words(OFS_TX_ID0, 1'b1, fr[i]);
        end
        bus_xfer(1'b0, OFS_TX_EMPTY, 32'h7, q);
        rd_chk(OFS_TX_EMPTY, 32'h0);
        check32({31'h0, tx_busy}, 32'h1);
        rd_chk(OFS_TX_ID0, 32'h0);
        // write to a queued buffer must be dropped
        bus_xfer(1'b0, OFS_TX_ID0, 32'hff, q);
        wait_frame(8'h01, arb_seq(fr[2]));
        wait_frame(8'h02, arb_seq(fr[1]));
        wait_frame(8'h03, arb_seq(fr[0]));
        rd_chk(OFS_TX_EMPTY, 32'h7);
        id_words(OFS_TX_ID0, 1'b0, fr[2]);
        check32({31'h0, tx_busy}, 32'h0);
        $display("test transmit_order done");
        // extended remote frame, srr sampled low
        rf = '{ext: 1'b1, id: 29'h0765_4321, srr: 1'b0, rtr: 1'b1};
        rx_send(rf);
        rd_chk(OFS_RX_FULL, 32'h1);
        id_words(OFS_RX_ID0, 1'b0, rf);
        bus_xfer(1'b0, OFS_RX_ID0, 32'hff, q);
        rx_send('{ext: 1'b1, id: 29'h0000001, srr: 1'b1, rtr: 1'b0});
        id_words(OFS_RX_ID0, 1'b0, rf);
        rd_chk(OFS_STATUS, 32'h4);
        bus_xfer(1'b0, OFS_STATUS, 32'h4, q);
        rd_chk(OFS_STATUS, 32'h0);
        $display("test receive_extended done");
        // standard data frame
        bus_xfer(1'b0, OFS_RX_FULL, 32'h1, q);
        rf = '{ext: 1'b0, id: 29'h00005a3, srr: 1'b0, rtr: 1'b0};
        rx_send(rf);
        id_words(OFS_RX_ID0, 1'b0, rf);
        bus_xfer(1'b0, OFS_RX_FULL, 32'h1, q);
        rd_chk(OFS_RX_ID0, 32'h0);
        $display("test receive_standard done");
        wrap_up();
    end
endmodule
